// ===== hdl/radio_fsm_status_control.sv
`timescale 1ns/100ps
module radio_fsm_status_control #(
  parameter int unsigned ACK_WAIT_CYCLES = radio_fsm_pkg::ACK_WAIT_CYCLES
) (
  // clock and reset
  input wire logic mclk_in,
  input wire logic rst_in,
  // register access
  input wire logic [11:0] reg_addr_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [7:0] reg_wdata_in,
  output logic [7:0] reg_rdata_out,
  // calibration and state machine
  input wire logic cal_ready_in,
  input wire logic calibration_in_progress_in,
  input wire logic [5:0] frame_control_state_in,
  input wire logic tx_state_in,
  input wire logic rx_state_in,
  input wire logic pll_lock_in,
  // receive buffer
  input wire logic [7:0] rx_count_in,
  input wire logic rx_overflow_in,
  input wire logic rx_frame_buffered_in,
  input wire logic rx_byte_read_in,
  // delimiter events
  input wire logic tx_sfd_sent_in,
  input wire logic tx_frame_end_in,
  input wire logic rx_sfd_seen_in,
  input wire logic rx_frame_end_in,
  // channel assessment
  input wire logic [1:0] channel_assessment_mode_in,
  input wire logic rssi_below_low_in,
  input wire logic rssi_at_or_above_in,
  input wire logic receiving_frame_in,
  input wire logic sample_assessment_strobe_in,
  input wire logic transmit_if_clear_strobe_in,
  // acknowledge timing
  input wire logic ack_request_in,
  input wire logic backoff_boundary_in,
  output logic ack_tx_start_out,
  output logic rx_timeout_active_out,
  // flags
  output logic frame_pending_flag_out,
  output logic channel_clear_out
);
  timer_if tif();

  logic cal_ready_reg;
  logic calibration_in_progress_reg;
  logic [5:0] state_field_reg;
  logic data_present_reg;
  logic frame_pending_reg;
  logic sfd_reg;
  logic cca_reg;
  logic captured_cca_reg;
  logic lock_reg;
  logic tx_active_reg;
  logic rx_active_reg;
  logic [6:0] threshold_reg;
  logic slotted_reg;
  logic timeout_en_reg;
  logic [7:0] rdata_reg;
  logic ack_start_reg;
  logic timeout_reg;
  logic cca_next;
  logic fp_set;
  logic fp_clear;
  radio_fsm_pkg::assess_mode_t mode;

  function automatic logic [7:0] pad7(input logic [6:0] v);
    pad7 = {1'b0, v};
  endfunction

  assign mode = radio_fsm_pkg::assess_mode_t'(channel_assessment_mode_in);

  // plain status sampling
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      cal_ready_reg <= 1'b0;
      calibration_in_progress_reg <= 1'b0;
      state_field_reg <= 6'h00;
      lock_reg <= 1'b0;
      tx_active_reg <= 1'b0;
      rx_active_reg <= 1'b0;
    end else begin
      cal_ready_reg <= cal_ready_in;
      calibration_in_progress_reg <= calibration_in_progress_in;
      state_field_reg <= frame_control_state_in;
      lock_reg <= pll_lock_in;
      tx_active_reg <= tx_state_in;
      rx_active_reg <= rx_state_in;
    end
  end

  // receive buffer flags
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      data_present_reg <= 1'b0;
    end else begin
      data_present_reg <= (rx_count_in != 8'h00) && !rx_overflow_in;
    end
  end

  assign fp_set = (rx_count_in > pad7(threshold_reg)) || rx_frame_buffered_in || rx_overflow_in;
  assign fp_clear = rx_byte_read_in && (rx_count_in < pad7(threshold_reg));

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      frame_pending_reg <= 1'b0;
    end else if (fp_set) begin
      frame_pending_reg <= 1'b1;
    end else if (fp_clear) begin
      frame_pending_reg <= 1'b0;
    end
  end

  // delimiter flag, set wins over clear
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      sfd_reg <= 1'b0;
    end else if (tx_sfd_sent_in || rx_sfd_seen_in) begin
      sfd_reg <= 1'b1;
    end else if (tx_frame_end_in || rx_frame_end_in) begin
      sfd_reg <= 1'b0;
    end
  end

  // channel assessment with hysteresis
  always_comb begin
    cca_next = cca_reg;
    case (mode)
      radio_fsm_pkg::CCA_ALWAYS: cca_next = 1'b1;
      radio_fsm_pkg::CCA_RSSI: begin
        if (rssi_at_or_above_in) begin
          cca_next = 1'b0;
        end else if (rssi_below_low_in) begin
          cca_next = 1'b1;
        end
      end
      radio_fsm_pkg::CCA_NOT_RX: cca_next = !receiving_frame_in;
      radio_fsm_pkg::CCA_BOTH: begin
        if (rssi_at_or_above_in || receiving_frame_in) begin
          cca_next = 1'b0;
        end else if (rssi_below_low_in) begin
          cca_next = 1'b1;
        end
      end
      default: cca_next = 1'b0;
    endcase
  end

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      cca_reg <= 1'b0;
    end else begin
      cca_reg <= cca_next;
    end
  end

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      captured_cca_reg <= 1'b0;
    end else if (sample_assessment_strobe_in || transmit_if_clear_strobe_in) begin
      captured_cca_reg <= cca_reg;
    end
  end

  // writable registers
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      threshold_reg <= radio_fsm_pkg::RST_THRESHOLD;
      slotted_reg <= radio_fsm_pkg::RST_OPTIONS[radio_fsm_pkg::BIT_BACKOFF_ACK];
      timeout_en_reg <= radio_fsm_pkg::RST_OPTIONS[radio_fsm_pkg::BIT_TIMEOUT_EN];
    end else if (reg_wr_in) begin
      if (reg_addr_in == radio_fsm_pkg::ADDR_THRESHOLD) begin
        threshold_reg <= reg_wdata_in[6:0];
      end
      if (reg_addr_in == radio_fsm_pkg::ADDR_OPTIONS) begin
        slotted_reg <= reg_wdata_in[radio_fsm_pkg::BIT_BACKOFF_ACK];
        timeout_en_reg <= reg_wdata_in[radio_fsm_pkg::BIT_TIMEOUT_EN];
      end
    end
  end

  // read data, one cycle after the read request
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      rdata_reg <= radio_fsm_pkg::RST_STATUS;
    end else if (reg_rd_in) begin
      case (reg_addr_in)
        radio_fsm_pkg::ADDR_STATE_CAL: rdata_reg <= {cal_ready_reg, calibration_in_progress_reg, state_field_reg};
        radio_fsm_pkg::ADDR_FLAGS: rdata_reg <= {data_present_reg, frame_pending_reg, sfd_reg, cca_reg,
          captured_cca_reg, lock_reg, tx_active_reg, rx_active_reg};
        radio_fsm_pkg::ADDR_THRESHOLD: rdata_reg <= pad7(threshold_reg);
        radio_fsm_pkg::ADDR_OPTIONS: rdata_reg <= {6'h00, slotted_reg, timeout_en_reg};
        default: rdata_reg <= 8'h00;
      endcase
    end
  end

  // acknowledge and timeout timing
  assign tif.start_ack = ack_request_in;
  assign tif.slotted = slotted_reg;
  assign tif.slot_boundary = backoff_boundary_in;
  assign tif.rx_end = rx_frame_end_in;
  assign tif.timeout_en = timeout_en_reg;

  symbol_timer #(
    .WAIT_CYCLES(ACK_WAIT_CYCLES)
  ) u_timer (
    .mclk_in(mclk_in),
    .rst_in(rst_in),
    .tif(tif)
  );

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      ack_start_reg <= 1'b0;
      timeout_reg <= 1'b0;
    end else begin
      ack_start_reg <= tif.ack_fire;
      timeout_reg <= tif.timeout_busy;
    end
  end

  assign reg_rdata_out = rdata_reg;
  assign ack_tx_start_out = ack_start_reg;
  assign rx_timeout_active_out = timeout_reg;
  assign frame_pending_flag_out = frame_pending_reg;
  assign channel_clear_out = cca_reg;

  // checks
  sequence s_cal_pulse;
    cal_ready_in ##1 !cal_ready_in;
  endsequence
  sequence s_flag_pulse;
    cal_ready_reg ##1 !cal_ready_reg;
  endsequence

  AST_CAL_READY_PULSE: assert property (@(posedge mclk_in) disable iff (rst_in)
    s_cal_pulse |-> s_flag_pulse)
    else $error("calibration-ready flag not a single cycle");
  AST_CAL_PROGRESS_READ: assert property (@(posedge mclk_in) disable iff (rst_in)
    (reg_rd_in && reg_addr_in == radio_fsm_pkg::ADDR_STATE_CAL)
      |=> reg_rdata_out[radio_fsm_pkg::BIT_CAL_IN_PROGRESS] == $past(calibration_in_progress_reg))
    else $error("calibration-in-progress bit misreported");
  AST_STATE_FIELD: assert property (@(posedge mclk_in) disable iff (rst_in)
    ##1 state_field_reg == $past(frame_control_state_in))
    else $error("state field does not follow state machine");
  AST_DATA_PRESENT: assert property (@(posedge mclk_in) disable iff (rst_in)
    rx_overflow_in |=> !data_present_reg)
    else $error("data-present high during overflow");
  AST_FP_SET: assert property (@(posedge mclk_in) disable iff (rst_in)
    (rx_count_in > pad7(threshold_reg) || rx_frame_buffered_in) |=> frame_pending_reg)
    else $error("frame-pending not set");
  AST_FP_CLEAR: assert property (@(posedge mclk_in) disable iff (rst_in)
    (fp_clear && !fp_set) |=> !frame_pending_reg)
    else $error("frame-pending not cleared after read");
  AST_FP_OVERFLOW: assert property (@(posedge mclk_in) disable iff (rst_in)
    rx_overflow_in [*2] |=> frame_pending_reg)
    else $error("frame-pending low during overflow");
  AST_SFD_SET: assert property (@(posedge mclk_in) disable iff (rst_in)
    (tx_sfd_sent_in || rx_sfd_seen_in) |=> sfd_reg)
    else $error("delimiter flag not set");
  AST_SFD_CLEAR: assert property (@(posedge mclk_in) disable iff (rst_in)
    (rx_frame_end_in && !tx_sfd_sent_in && !rx_sfd_seen_in) |=> !sfd_reg)
    else $error("delimiter flag not cleared at frame end");
  AST_CCA_BUSY: assert property (@(posedge mclk_in) disable iff (rst_in)
    (mode == radio_fsm_pkg::CCA_BOTH && receiving_frame_in) |=> !channel_clear_out)
    else $error("channel clear while receiving in combined mode");
  AST_CCA_ALWAYS: assert property (@(posedge mclk_in) disable iff (rst_in)
    (mode == radio_fsm_pkg::CCA_ALWAYS) |=> channel_clear_out)
    else $error("channel not clear in always mode");
  AST_CCA_CAPTURE: assert property (@(posedge mclk_in) disable iff (rst_in)
    sample_assessment_strobe_in |=> captured_cca_reg == $past(cca_reg))
    else $error("captured channel clear wrong");
  AST_CCA_HOLD: assert property (@(posedge mclk_in) disable iff (rst_in)
    (!sample_assessment_strobe_in && !transmit_if_clear_strobe_in) |=> $stable(captured_cca_reg))
    else $error("captured channel clear changed without strobe");
  AST_LOCK_ACTIVE: assert property (@(posedge mclk_in) disable iff (rst_in)
    ##1 (lock_reg == $past(pll_lock_in) && tx_active_reg == $past(tx_state_in)
      && rx_active_reg == $past(rx_state_in)))
    else $error("lock or activity bit wrong");
  AST_THRESHOLD_WRITE: assert property (@(posedge mclk_in) disable iff (rst_in)
    (reg_wr_in && reg_addr_in == radio_fsm_pkg::ADDR_THRESHOLD) |=> threshold_reg == $past(reg_wdata_in[6:0]))
    else $error("threshold write lost");
  AST_ACK_NOT_EARLY: assert property (@(posedge mclk_in) disable iff (rst_in)
    ack_request_in |=> !ack_tx_start_out [*8])
    else $error("acknowledge started too early");

  // read-back, hold, and further write, flag and acknowledge checks
  sequence s_flags_read;
    reg_rd_in && reg_addr_in == radio_fsm_pkg::ADDR_FLAGS;
  endsequence
  AST_FLAGS_READ_BUF: assert property (@(posedge mclk_in) disable iff (rst_in)
    s_flags_read |=> reg_rdata_out[radio_fsm_pkg::BIT_DATA_PRESENT] == $past(data_present_reg)
      && reg_rdata_out[radio_fsm_pkg::BIT_FRAME_PENDING] == $past(frame_pending_reg))
    else $error("buffer flags misreported");
  AST_FLAGS_READ_LINK: assert property (@(posedge mclk_in) disable iff (rst_in)
    s_flags_read |=> reg_rdata_out[radio_fsm_pkg::BIT_SFD] == $past(sfd_reg)
      && reg_rdata_out[radio_fsm_pkg::BIT_LOCK] == $past(lock_reg))
    else $error("delimiter or lock bit misreported");
  AST_FLAGS_READ_CCA: assert property (@(posedge mclk_in) disable iff (rst_in)
    s_flags_read |=> reg_rdata_out[radio_fsm_pkg::BIT_CCA] == $past(cca_reg)
      && reg_rdata_out[radio_fsm_pkg::BIT_CAPTURED_CCA] == $past(captured_cca_reg))
    else $error("channel clear bits misreported");
  AST_FLAGS_READ_ACTIVE: assert property (@(posedge mclk_in) disable iff (rst_in)
    s_flags_read |=> reg_rdata_out[radio_fsm_pkg::BIT_TX_ACTIVE] == $past(tx_active_reg)
      && reg_rdata_out[radio_fsm_pkg::BIT_RX_ACTIVE] == $past(rx_active_reg))
    else $error("activity bits misreported");
  AST_THRESHOLD_READ: assert property (@(posedge mclk_in) disable iff (rst_in)
    (reg_rd_in && reg_addr_in == radio_fsm_pkg::ADDR_THRESHOLD)
      |=> reg_rdata_out == pad7($past(threshold_reg)))
    else $error("threshold read-back wrong");
  AST_OPTIONS_READ: assert property (@(posedge mclk_in) disable iff (rst_in)
    (reg_rd_in && reg_addr_in == radio_fsm_pkg::ADDR_OPTIONS) |=> reg_rdata_out[7:2] == 6'h00
      && reg_rdata_out[radio_fsm_pkg::BIT_BACKOFF_ACK] == $past(slotted_reg)
      && reg_rdata_out[radio_fsm_pkg::BIT_TIMEOUT_EN] == $past(timeout_en_reg))
    else $error("options read-back wrong");
  AST_RDATA_HOLD: assert property (@(posedge mclk_in) disable iff (rst_in)
    !reg_rd_in |=> $stable(reg_rdata_out))
    else $error("read data changed without a read");
  AST_OPTIONS_WRITE: assert property (@(posedge mclk_in) disable iff (rst_in)
    (reg_wr_in && reg_addr_in == radio_fsm_pkg::ADDR_OPTIONS)
      |=> slotted_reg == $past(reg_wdata_in[radio_fsm_pkg::BIT_BACKOFF_ACK])
      && timeout_en_reg == $past(reg_wdata_in[radio_fsm_pkg::BIT_TIMEOUT_EN]))
    else $error("options write lost");
  AST_FP_HOLD: assert property (@(posedge mclk_in) disable iff (rst_in)
    (!fp_set && !fp_clear) |=> $stable(frame_pending_reg))
    else $error("frame-pending changed without cause");
  AST_DATA_PRESENT_SET: assert property (@(posedge mclk_in) disable iff (rst_in)
    (rx_count_in != 8'h00 && !rx_overflow_in) |=> data_present_reg)
    else $error("data-present low with data");
  AST_SFD_TX_CLEAR: assert property (@(posedge mclk_in) disable iff (rst_in)
    (tx_frame_end_in && !tx_sfd_sent_in && !rx_sfd_seen_in) |=> !sfd_reg)
    else $error("delimiter flag not cleared after transmit");
  AST_CCA_NOT_RX: assert property (@(posedge mclk_in) disable iff (rst_in)
    (mode == radio_fsm_pkg::CCA_NOT_RX) |=> channel_clear_out == !$past(receiving_frame_in))
    else $error("channel clear wrong in receive mode");
  AST_CCA_RSSI_BUSY: assert property (@(posedge mclk_in) disable iff (rst_in)
    (mode == radio_fsm_pkg::CCA_RSSI && rssi_at_or_above_in) |=> !channel_clear_out)
    else $error("channel clear with strong signal");
  AST_CCA_TX_STROBE: assert property (@(posedge mclk_in) disable iff (rst_in)
    transmit_if_clear_strobe_in |=> captured_cca_reg == $past(cca_reg))
    else $error("captured channel clear wrong on transmit strobe");
  AST_ACK_OUT_PULSE: assert property (@(posedge mclk_in) disable iff (rst_in)
    ack_tx_start_out |=> !ack_tx_start_out)
    else $error("acknowledge start longer than one cycle");
endmodule // radio_fsm_status_control

// ===== hdl/radio_fsm_pkg.sv
package radio_fsm_pkg;
  localparam logic [11:0] ADDR_STATE_CAL = 12'h032;
  localparam logic [11:0] ADDR_FLAGS = 12'h033;
  localparam logic [11:0] ADDR_THRESHOLD = 12'h034;
  localparam logic [11:0] ADDR_OPTIONS = 12'h035;
  localparam logic [7:0] RST_STATUS = 8'h00;
  localparam logic [6:0] RST_THRESHOLD = 7'h40;
  localparam logic [7:0] RST_OPTIONS = 8'h01;
  localparam int BIT_CAL_READY = 7;
  localparam int BIT_CAL_IN_PROGRESS = 6;
  localparam int BIT_DATA_PRESENT = 7;
  localparam int BIT_FRAME_PENDING = 6;
  localparam int BIT_SFD = 5;
  localparam int BIT_CCA = 4;
  localparam int BIT_CAPTURED_CCA = 3;
  localparam int BIT_LOCK = 2;
  localparam int BIT_TX_ACTIVE = 1;
  localparam int BIT_RX_ACTIVE = 0;
  localparam int BIT_BACKOFF_ACK = 1;
  localparam int BIT_TIMEOUT_EN = 0;
  localparam int CLK_PERIOD_NS = 10;
  localparam int SYMBOL_NS = 16000;
  localparam int ACK_SYMBOLS = 12;
  localparam int ACK_WAIT_CYCLES = (ACK_SYMBOLS * SYMBOL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TIMER_W = 16;
  typedef enum logic [1:0] {
    CCA_ALWAYS = 2'b00,
    CCA_RSSI = 2'b01,
    CCA_NOT_RX = 2'b10,
    CCA_BOTH = 2'b11
  } assess_mode_t;
  typedef enum logic [1:0] {
    ACK_IDLE = 2'b00,
    ACK_COUNT = 2'b01,
    ACK_WAIT_SLOT = 2'b10
  } ack_state_t;
endpackage

// ===== hdl/timer_if.sv
`timescale 1ns/100ps
interface timer_if;
  logic start_ack;
  logic slotted;
  logic slot_boundary;
  logic rx_end;
  logic timeout_en;
  logic ack_fire;
  logic timeout_busy;
  modport ctl(output start_ack, output slotted, output slot_boundary, output rx_end, output timeout_en,
    input ack_fire, input timeout_busy);
  modport tmr(input start_ack, input slotted, input slot_boundary, input rx_end, input timeout_en,
    output ack_fire, output timeout_busy);
endinterface // timer_if

// ===== hdl/symbol_timer.sv
`timescale 1ns/100ps
module symbol_timer #(
  parameter int unsigned WAIT_CYCLES = radio_fsm_pkg::ACK_WAIT_CYCLES
) (
  input wire logic mclk_in,
  input wire logic rst_in,
  timer_if.tmr tif
);
  radio_fsm_pkg::ack_state_t ack_state_reg;
  logic [radio_fsm_pkg::TIMER_W-1:0] ack_cnt_reg;
  logic [radio_fsm_pkg::TIMER_W-1:0] tmo_cnt_reg;
  logic fire_reg;
  logic busy_reg;

  assign tif.ack_fire = fire_reg;
  assign tif.timeout_busy = busy_reg;

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      ack_state_reg <= radio_fsm_pkg::ACK_IDLE;
      ack_cnt_reg <= '0;
      fire_reg <= 1'b0;
    end else begin
      fire_reg <= 1'b0;
      case (ack_state_reg)
        radio_fsm_pkg::ACK_IDLE: begin
          if (tif.start_ack) begin
            ack_cnt_reg <= radio_fsm_pkg::TIMER_W'(WAIT_CYCLES - 1);
            ack_state_reg <= radio_fsm_pkg::ACK_COUNT;
          end
        end
        radio_fsm_pkg::ACK_COUNT: begin
          if (ack_cnt_reg != '0) begin
            ack_cnt_reg <= ack_cnt_reg - 1'b1;
          end else if (tif.slotted) begin
            ack_state_reg <= radio_fsm_pkg::ACK_WAIT_SLOT;
          end else begin
            fire_reg <= 1'b1;
            ack_state_reg <= radio_fsm_pkg::ACK_IDLE;
          end
        end
        radio_fsm_pkg::ACK_WAIT_SLOT: begin
          if (tif.slot_boundary) begin
            fire_reg <= 1'b1;
            ack_state_reg <= radio_fsm_pkg::ACK_IDLE;
          end
        end
        default: ack_state_reg <= radio_fsm_pkg::ACK_IDLE;
      endcase
    end
  end

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      tmo_cnt_reg <= '0;
      busy_reg <= 1'b0;
    end else if (tif.rx_end && tif.timeout_en) begin
      tmo_cnt_reg <= radio_fsm_pkg::TIMER_W'(WAIT_CYCLES - 1);
      busy_reg <= 1'b1;
    end else if (busy_reg) begin
      if (tmo_cnt_reg == '0) begin
        busy_reg <= 1'b0;
      end else begin
        tmo_cnt_reg <= tmo_cnt_reg - 1'b1;
      end
    end
  end

  AST_ACK_UNSLOTTED_TIME: assert property (@(posedge mclk_in) disable iff (rst_in)
    (ack_state_reg == radio_fsm_pkg::ACK_COUNT && ack_cnt_reg == '0 && !tif.slotted) |=> fire_reg)
    else $error("unslotted acknowledge not fired at count end");
  AST_ACK_SLOT_WAIT: assert property (@(posedge mclk_in) disable iff (rst_in)
    (ack_state_reg == radio_fsm_pkg::ACK_WAIT_SLOT && !tif.slot_boundary) |=> !fire_reg)
    else $error("slotted acknowledge fired off a boundary");
  AST_TIMEOUT_OFF: assert property (@(posedge mclk_in) disable iff (rst_in)
    (tif.rx_end && !tif.timeout_en && !busy_reg) |=> !busy_reg)
    else $error("timeout started while disabled");
endmodule // symbol_timer

// ===== dv/reg_host.sv
`timescale 1ns/100ps
module reg_host (
  // clock
  input wire logic mclk_in,
  // register port toward the device
  output logic [11:0] addr_out,
  output logic wr_out,
  output logic rd_out,
  output logic [7:0] wdata_out,
  input wire logic [7:0] rdata_in,
  // read completion toward the monitor
  output logic done_out,
  output logic [7:0] data_out
);
  initial begin
    addr_out = 12'h000;
    wr_out = 1'b0;
    rd_out = 1'b0;
    wdata_out = 8'h00;
    done_out = 1'b0;
    data_out = 8'h00;
  end
  // one-cycle strobe; bus shows inverted leftovers once released
  task automatic write_reg(input logic [11:0] a, input logic [7:0] d);
    @(negedge mclk_in);
    done_out = 1'b0;
    addr_out = a;
    wdata_out = d;
    wr_out = 1'b1;
    @(negedge mclk_in);
    wr_out = 1'b0;
    addr_out = ~a;
    wdata_out = ~d;
  endtask
  task automatic read_reg(input logic [11:0] a);
    @(negedge mclk_in);
    done_out = 1'b0;
    addr_out = a;
    rd_out = 1'b1;
    @(negedge mclk_in);
    rd_out = 1'b0;
    addr_out = ~a;
    data_out = rdata_in;
    done_out = 1'b1;
  endtask
endmodule // reg_host

// ===== dv/radio_fsm_status_control_test.sv
`timescale 1ns/100ps
module radio_fsm_status_control_test;
  localparam int unsigned WAIT = 20;
  localparam logic [11:0] A0 = radio_fsm_pkg::ADDR_STATE_CAL;
  localparam logic [11:0] A1 = radio_fsm_pkg::ADDR_FLAGS;
  localparam logic [11:0] A2 = radio_fsm_pkg::ADDR_THRESHOLD;
  localparam logic [11:0] A3 = radio_fsm_pkg::ADDR_OPTIONS;
  logic mclk_in, rst_in, reg_wr_in, reg_rd_in, cal_ready_in, calibration_in_progress_in;
  logic tx_state_in, rx_state_in, pll_lock_in, rx_overflow_in, rx_frame_buffered_in, rx_byte_read_in;
  logic tx_sfd_sent_in, tx_frame_end_in, rx_sfd_seen_in, rx_frame_end_in;
  logic rssi_below_low_in, rssi_at_or_above_in, receiving_frame_in;
  logic sample_assessment_strobe_in, transmit_if_clear_strobe_in, ack_request_in, backoff_boundary_in;
  logic ack_tx_start_out, rx_timeout_active_out, frame_pending_flag_out, channel_clear_out, host_done;
  logic [11:0] reg_addr_in;
  logic [7:0] reg_wdata_in, reg_rdata_out, rx_count_in, host_data;
  logic [5:0] frame_control_state_in;
  logic [1:0] channel_assessment_mode_in;
  logic [31:0] r;
  int n_fail = 0;
  int n_compared = 0;
  int cyc = 0;
  int seed = 32'h0A2E1F08;
  logic [15:0] exp_q [$];
  int ack_q [$];
  // {tx_sfd, tx_end, rx_sfd, rx_end, flag}
  logic [4:0] sfd_steps [6] = '{5'h11, 5'h08, 5'h19, 5'h02, 5'h05, 5'h02};
  // {count, buffered, overflow, read, flag}
  logic [11:0] fp_steps [10] = '{12'h050, 12'h061, 12'h053, 12'h041, 12'h042,
    12'h009, 12'h002, 12'h007, 12'h007, 12'h002};
  // {mode, below, above, receiving, clear}
  logic [5:0] cca_steps [10] = '{6'h07, 6'h19, 6'h11, 6'h14, 6'h12, 6'h25, 6'h2A, 6'h39, 6'h3A, 6'h34};

  radio_fsm_status_control #(.ACK_WAIT_CYCLES(WAIT)) dut (.*);
  reg_host host (.mclk_in(mclk_in), .addr_out(reg_addr_in), .wr_out(reg_wr_in), .rd_out(reg_rd_in),
    .wdata_out(reg_wdata_in), .rdata_in(reg_rdata_out), .done_out(host_done), .data_out(host_data));

  initial begin
    mclk_in = 1'b0;
    forever #5 mclk_in = ~mclk_in;
  end
  always @(posedge mclk_in) cyc <= cyc + 1;

  task automatic cmp_val(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic cmp_cyc(input string what, input int exp, input int got);
    n_compared++;
    if (got != exp) begin
      n_fail++;
      $display("[ERR] %s expected %0d seen %0d", what, exp, got);
    end
  endtask
  task automatic print_verdict();
    if (n_fail == 0 && n_compared > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic nclk(input int n);
    repeat (n) @(negedge mclk_in);
  endtask
  task automatic rd_exp(input logic [11:0] a, input logic [7:0] m, input logic [7:0] v);
    exp_q.push_back({m, v});
    host.read_reg(a);
  endtask
  task automatic watch_timeout(input int exp_first, input int exp_len);
    int first = -1;
    int len = 0;
    repeat (40) begin
      @(negedge mclk_in);
      rx_frame_end_in = 1'b0;
      if (rx_timeout_active_out === 1'b1) begin
        if (len == 0) first = cyc;
        len++;
      end
    end
    cmp_cyc("timeout start", exp_first, first);
    cmp_cyc("timeout length", exp_len, len);
  endtask

  // monitors: oldest note against each result
  always @(posedge host_done) begin
    logic [15:0] e;
    e = exp_q.pop_front();
    cmp_val("read data", e[7:0], host_data & e[15:8]);
  end
  always @(negedge mclk_in) begin
    if (ack_tx_start_out === 1'b1) cmp_cyc("ack start", ack_q.size() ? ack_q.pop_front() : -1, cyc);
  end

  initial begin
    #50000;
    n_fail++;
    print_verdict();
  end

  initial begin
    rst_in = 1'b1;
    {cal_ready_in, calibration_in_progress_in, frame_control_state_in, tx_state_in, rx_state_in, pll_lock_in,
      rx_count_in, rx_overflow_in, rx_frame_buffered_in, rx_byte_read_in, tx_sfd_sent_in, tx_frame_end_in,
      rx_sfd_seen_in, rx_frame_end_in, channel_assessment_mode_in, rssi_below_low_in, rssi_at_or_above_in,
      receiving_frame_in, sample_assessment_strobe_in, transmit_if_clear_strobe_in, ack_request_in,
      backoff_boundary_in} = '0;
    repeat (5) @(posedge mclk_in);
    @(negedge mclk_in);
    rst_in = 1'b0;
    // reset values, then access kinds
    rd_exp(A0, 8'hFF, radio_fsm_pkg::RST_STATUS);
    rd_exp(A1, 8'hEF, radio_fsm_pkg::RST_STATUS);
    rd_exp(A2, 8'hFF, {1'b0, radio_fsm_pkg::RST_THRESHOLD});
    rd_exp(A3, 8'hFF, radio_fsm_pkg::RST_OPTIONS);
    rd_exp(12'h040, 8'hFF, 8'h00);
    host.write_reg(A2, 8'hFF);
    rd_exp(A2, 8'hFF, 8'h7F);
    host.write_reg(A3, 8'hFF);
    rd_exp(A3, 8'hFF, 8'h03);
    host.write_reg(A0, 8'hFF);
    host.write_reg(12'h040, 8'h12);
    rd_exp(A0, 8'hFF, 8'h00);
    rd_exp(12'h040, 8'hFF, 8'h00);
    host.write_reg(A2, 8'h05);
    // slotted: boundary at exactly twelve symbols is too early
    @(negedge mclk_in);
    ack_request_in = 1'b1;
    ack_q.push_back(cyc + WAIT + 7);
    nclk(1);
    ack_request_in = 1'b0;
    nclk(19);
    backoff_boundary_in = 1'b1;
    nclk(1);
    backoff_boundary_in = 1'b0;
    nclk(4);
    backoff_boundary_in = 1'b1;
    nclk(1);
    backoff_boundary_in = 1'b0;
    nclk(5);
    // unslotted, second request while pending is dropped
    host.write_reg(A3, 8'h01);
    @(negedge mclk_in);
    ack_request_in = 1'b1;
    ack_q.push_back(cyc + WAIT + 2);
    nclk(1);
    ack_request_in = 1'b0;
    nclk(4);
    ack_request_in = 1'b1;
    nclk(1);
    ack_request_in = 1'b0;
    nclk(25);
    @(negedge mclk_in);
    rx_frame_end_in = 1'b1;
    watch_timeout(cyc + 2, WAIT);
    host.write_reg(A3, 8'h00);
    @(negedge mclk_in);
    rx_frame_end_in = 1'b1;
    watch_timeout(-1, 0);
    foreach (sfd_steps[i]) begin
      @(negedge mclk_in);
      {tx_sfd_sent_in, tx_frame_end_in, rx_sfd_seen_in, rx_frame_end_in} = sfd_steps[i][4:1];
      @(negedge mclk_in);
      {tx_sfd_sent_in, tx_frame_end_in, rx_sfd_seen_in, rx_frame_end_in} = 4'h0;
      rd_exp(A1, 8'h20, {2'b00, sfd_steps[i][0], 5'h00});
    end
    foreach (fp_steps[i]) begin
      @(negedge mclk_in);
      {rx_count_in, rx_frame_buffered_in, rx_overflow_in, rx_byte_read_in} = fp_steps[i][11:1];
      @(negedge mclk_in);
      rx_byte_read_in = 1'b0;
      cmp_val("frame pending", {7'h00, fp_steps[i][0]}, {7'h00, frame_pending_flag_out});
    end
    foreach (cca_steps[i]) begin
      @(negedge mclk_in);
      {channel_assessment_mode_in, rssi_below_low_in, rssi_at_or_above_in, receiving_frame_in} = cca_steps[i][5:1];
      @(negedge mclk_in);
      cmp_val("channel clear", {7'h00, cca_steps[i][0]}, {7'h00, channel_clear_out});
    end
    // captured value holds until the next strobe of either kind
    @(negedge mclk_in);
    {channel_assessment_mode_in, rssi_below_low_in, rssi_at_or_above_in, receiving_frame_in} = 5'h1C;
    nclk(1);
    sample_assessment_strobe_in = 1'b1;
    nclk(1);
    sample_assessment_strobe_in = 1'b0;
    rssi_below_low_in = 1'b0;
    rssi_at_or_above_in = 1'b1;
    nclk(1);
    rd_exp(A1, 8'h18, 8'h08);
    transmit_if_clear_strobe_in = 1'b1;
    nclk(1);
    transmit_if_clear_strobe_in = 1'b0;
    rd_exp(A1, 8'h08, 8'h00);
    repeat (8) begin
      @(negedge mclk_in);
      r = $random(seed);
      {calibration_in_progress_in, frame_control_state_in, pll_lock_in, tx_state_in, rx_state_in, rx_overflow_in} = r[10:0];
      rx_count_in = {6'h00, r[12:11]};
      rd_exp(A0, 8'hFF, {1'b0, r[10:4]});
      rd_exp(A1, 8'h87, {(r[12:11] != 2'h0) && !r[0], 4'h0, r[3:1]});
    end
    @(negedge mclk_in);
    calibration_in_progress_in = 1'b0;
    cal_ready_in <= 1'b1;
    cal_ready_in <= #10 1'b0;
    rd_exp(A0, 8'h80, 8'h80);
    rd_exp(A0, 8'hC0, 8'h00);
    calibration_in_progress_in = 1'b1;
    rd_exp(A0, 8'h40, 8'h40);
    calibration_in_progress_in = 1'b0;
    rd_exp(A0, 8'h40, 8'h00);
    nclk(5);
    cmp_cyc("acks left", 0, ack_q.size());
    cmp_cyc("reads left", 0, exp_q.size());
    print_verdict();
  end
endmodule // radio_fsm_status_control_test
